// ### core/fca_addr_config.sv
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module fca_addr_config
  import fca_pkg::*;
#(
  parameter int DW = 24
)(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_srst,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Datapath events.
  input wire logic i_sample_step,
  input wire logic i_coef_step,
  input wire logic i_session_start,
  input wire logic i_input_empty,
  input wire logic i_output_full,
  input wire logic signed [DW-1:0] i_mac_result,
  // Outputs.
  output logic [15:0] o_sample_addr,
  output logic [15:0] o_coef_addr,
  output logic signed [DW-1:0] o_scaled_result,
  output logic o_run_on,
  output logic o_irq_in_req,
  output logic o_irq_out_req,
  output logic [7:0] o_irq_vector,
  output logic o_dma_req11,
  output logic o_dma_req12
);
  if (DW < 8)
  begin : g_dw_chk
    $error("DW too small");
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [2:0] ctrl_r;
  logic [1:0] scale_r;
  logic [11:0] len_r;
  logic [15:0] sptr_r;
  logic [15:0] cptr_r;
  logic [15:0] cstep_r;
  logic [23:0] dcc_r;
  logic [5:0] chan_r;
  fca_state_t state_r;
  fca_state_t state_nxt;
  logic [15:0] sptr_nxt;
  logic [15:0] cstep_nxt;
  logic [5:0] chan_nxt;

  wire wr_en = i_psel & i_penable & i_pwrite;
  wire run = ctrl_r[FCA_CTRL_RUN];
  wire running = state_r == FCA_RUN;

  // ****************************************************************
  // Ring bounds
  // ****************************************************************
  // Ring size M as 13 bits so a full 4096 entry ring fits.
  wire [12:0] ring_m = {1'b0, len_r} + 13'h0001;
  logic [15:0] kmask;
  always_comb
  begin
    kmask = 16'h0000;
    for (int i = 0; i < 13; i++)
    begin
      if ((13'h0001 << i) < ring_m)
      begin
        kmask[i] = 1'b1;
      end
    end
  end
  // Mask covers the k low bits with 2^k >= M.
  wire [15:0] s_low = sptr_r & ~kmask;
  wire [15:0] s_up = s_low + {3'h0, len_r};
  wire [15:0] c_low = cptr_r & ~kmask;
  wire [15:0] c_up = c_low + {3'h0, len_r};
  // Each channel owns one 2^k block, so the channel index is
  // added above the ring bits in both banks.
  wire [15:0] chan_off = ({10'h000, chan_r} << $countones(kmask));

  always_comb
  begin
    sptr_nxt = sptr_r;
    if (running && i_sample_step)
    begin
      sptr_nxt = (sptr_r == s_up) ? s_low : sptr_r + 16'h0001;
    end
  end

  always_comb
  begin
    cstep_nxt = cstep_r;
    if (!running || i_session_start)
    begin
      cstep_nxt = c_low;
    end
    else if (i_coef_step && cstep_r != c_up)
    begin
      cstep_nxt = cstep_r + 16'h0001;
    end
  end

  // Channel index advances on each session start; all channels
  // share config, so this index is internal logic reset on stop.
  always_comb
  begin
    chan_nxt = chan_r;
    if (!running)
    begin
      chan_nxt = 6'h00;
    end
    else if (i_session_start)
    begin
      chan_nxt = (chan_r == dcc_r[FCA_CHL_LSB +: 6]) ? 6'h00 :
        chan_r + 6'h01;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      FCA_IDLE: if (run) state_nxt = FCA_RUN;
      FCA_RUN: if (!run) state_nxt = FCA_IDLE;
      default: state_nxt = FCA_IDLE;
    endcase
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  wire stopped_wr = wr_en & ~run;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ctrl_r <= 3'h0;
      scale_r <= FCA_SCALE_RST;
      len_r <= FCA_LEN_RST;
      sptr_r <= FCA_PTR_RST;
      cptr_r <= FCA_PTR_RST;
      dcc_r <= FCA_DCC_RST;
      state_r <= FCA_IDLE;
      cstep_r <= FCA_PTR_RST;
      chan_r <= 6'h00;
    end
    else
    begin
      state_r <= state_nxt;
      cstep_r <= cstep_nxt;
      chan_r <= chan_nxt;
      sptr_r <= sptr_nxt;
      if (wr_en && i_paddr == FCA_ADDR_CTRL)
        ctrl_r <= i_pwdata[2:0];
      // Scale, length and DCC writes during run are dropped to keep the datapath sane; pointer writes always land.
      if (stopped_wr && i_paddr == FCA_ADDR_ARITH)
        scale_r <= i_pwdata[1:0];
      if (stopped_wr && i_paddr == FCA_ADDR_LEN)
        len_r <= i_pwdata[11:0];
      if (wr_en && i_paddr == FCA_ADDR_SPTR)
        sptr_r <= i_pwdata[15:0];
      if (wr_en && i_paddr == FCA_ADDR_CPTR)
        cptr_r <= i_pwdata[15:0];
      if (stopped_wr && i_paddr == FCA_ADDR_DCC)
      begin
        dcc_r <= {12'h000, i_pwdata[11:8], 2'h0, i_pwdata[5:0]};
      end
    end
  end

  // ****************************************************************
  // Read mux and outputs
  // ****************************************************************
  logic [31:0] rd_mux;
  logic hit;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    hit = 1'b1;
    case (i_paddr)
      FCA_ADDR_CTRL: rd_mux = {29'h0, ctrl_r};
      FCA_ADDR_ARITH: rd_mux = {30'h0, scale_r};
      FCA_ADDR_LEN: rd_mux = {20'h0, len_r};
      FCA_ADDR_SPTR: rd_mux = {16'h0, sptr_r};
      FCA_ADDR_CPTR: rd_mux = {16'h0, c_low};
      FCA_ADDR_DCC: rd_mux = {8'h0, dcc_r};
      FCA_ADDR_STAT: rd_mux = {28'h0, i_output_full, i_input_empty,
        running, run};
      FCA_ADDR_SCALE: rd_mux = {16'h0, cstep_r};
      default: hit = 1'b0;
    endcase
  end

  logic signed [DW-1:0] scaled;
  always_comb
  begin
    case (scale_r)
      FCA_SCL_X8: scaled = i_mac_result <<< 3;
      FCA_SCL_X16: scaled = i_mac_result <<< 4;
      default: scaled = i_mac_result;
    endcase
  end

  wire irq_in = running & i_input_empty & ctrl_r[FCA_CTRL_IIE];
  wire irq_out = running & i_output_full & ctrl_r[FCA_CTRL_OIE];
  wire [7:0] vec = irq_in ? FCA_VEC_IN : FCA_VEC_OUT;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_sample_addr <= FCA_PTR_RST;
      o_coef_addr <= FCA_PTR_RST;
      o_scaled_result <= '0;
      o_run_on <= 1'b0;
      o_irq_in_req <= 1'b0;
      o_irq_out_req <= 1'b0;
      o_irq_vector <= 8'h00;
      o_dma_req11 <= 1'b0;
      o_dma_req12 <= 1'b0;
    end
    else
    begin
      o_pready <= i_psel & ~i_penable;
      o_prdata <= rd_mux;
      o_pslverr <= i_psel & ~i_penable & ~hit;
      o_sample_addr <= sptr_nxt + chan_off;
      o_coef_addr <= cstep_nxt + chan_off;
      o_scaled_result <= scaled;
      o_run_on <= running;
      o_irq_in_req <= irq_in;
      o_irq_out_req <= irq_out;
      o_irq_vector <= vec;
      o_dma_req11 <= running & i_input_empty;
      o_dma_req12 <= running & i_output_full;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_wrap;
    @(posedge i_clk) disable iff (i_srst)
    running && i_sample_step && sptr_r == s_up && !wr_en |=>
      sptr_r == $past(s_low);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
  property p_cread;
    @(posedge i_clk) disable iff (i_srst)
    hit && i_paddr == FCA_ADDR_CPTR |=> o_prdata == {16'h0, $past(c_low)};
  endproperty
  a_cread: assert property (p_cread) else $error("bad cptr read");
  property p_dcc_hold;
    @(posedge i_clk) disable iff (i_srst) run |=> $stable(dcc_r);
  endproperty
  a_dcc_hold: assert property (p_dcc_hold) else $error("dcc lost");
  property p_dma;
    @(posedge i_clk) disable iff (i_srst)
    running && i_input_empty |=> o_dma_req11;
  endproperty
  a_dma: assert property (p_dma) else $error("no dma 11");
  property p_irq;
    @(posedge i_clk) disable iff (i_srst) irq_in |=> o_irq_vector == 8'h68;
  endproperty
  a_irq: assert property (p_irq) else $error("bad vector");
  property p_irq2;
    @(posedge i_clk) disable iff (i_srst)
    irq_out && !irq_in |=> o_irq_out_req && o_irq_vector == 8'h6a;
  endproperty
  a_irq2: assert property (p_irq2) else $error("bad out irq");
  property p_rsv;
    @(posedge i_clk) disable iff (i_srst)
    dcc_r[23:12] == 12'h0 && dcc_r[7:6] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_scl;
    @(posedge i_clk) disable iff (i_srst)
    scale_r == 2'h3 |=> o_scaled_result == $past(i_mac_result);
  endproperty
  a_scl: assert property (p_scl) else $error("bad scale");
  property p_scl8;
    @(posedge i_clk) disable iff (i_srst)
    scale_r == FCA_SCL_X8 |=> o_scaled_result == ($past(i_mac_result) <<< 3);
  endproperty
  a_scl8: assert property (p_scl8) else $error("bad x8");
  property p_stop;
    @(posedge i_clk) disable iff (i_srst)
    !run |-> ##2 !(o_irq_in_req || o_irq_out_req ||
      o_dma_req11 || o_dma_req12);
  endproperty
  a_stop: assert property (p_stop) else $error("live when off");
  property p_cwalk;
    @(posedge i_clk) disable iff (i_srst)
    running && i_session_start |=> cstep_r == $past(c_low);
  endproperty
  a_cwalk: assert property (p_cwalk) else $error("bad start");
  property p_cend;
    @(posedge i_clk) disable iff (i_srst)
    running && i_coef_step && !i_session_start && !wr_en &&
      cstep_r == c_up |=> cstep_r == $past(c_up);
  endproperty
  a_cend: assert property (p_cend) else $error("walk past end");
  c_wrap: cover property (@(posedge i_clk)
    running && i_sample_step && sptr_r == s_up);
  c_run: cover property (@(posedge i_clk) state_r == FCA_IDLE ##1 running);
  c_scl: cover property (@(posedge i_clk) running && scale_r == FCA_SCL_X16);
  c_irq: cover property (@(posedge i_clk) irq_in && irq_out);
endmodule // fca_addr_config

// ### core/fca_pkg.sv
package fca_pkg;
  // Register byte addresses on APB.
  localparam logic [7:0] FCA_ADDR_CTRL = 8'h00;
  localparam logic [7:0] FCA_ADDR_ARITH = 8'h04;
  localparam logic [7:0] FCA_ADDR_LEN = 8'h08;
  localparam logic [7:0] FCA_ADDR_SPTR = 8'h0c;
  localparam logic [7:0] FCA_ADDR_CPTR = 8'h10;
  localparam logic [7:0] FCA_ADDR_DCC = 8'h14;
  localparam logic [7:0] FCA_ADDR_STAT = 8'h18;
  localparam logic [7:0] FCA_ADDR_SCALE = 8'h1c;
  // Control register bit positions.
  localparam int FCA_CTRL_RUN = 0;
  localparam int FCA_CTRL_IIE = 1;
  localparam int FCA_CTRL_OIE = 2;
  // Field positions in the decimation and channel register.
  localparam int FCA_DEC_LSB = 8;
  localparam int FCA_CHL_LSB = 0;
  // Reset values.
  localparam logic [1:0] FCA_SCALE_RST = 2'h0;
  localparam logic [23:0] FCA_DCC_RST = 24'h000000;
  localparam logic [15:0] FCA_PTR_RST = 16'h0000;
  localparam logic [11:0] FCA_LEN_RST = 12'h000;
  // Scale select codes.
  localparam logic [1:0] FCA_SCL_NONE = 2'h0;
  localparam logic [1:0] FCA_SCL_X8 = 2'h1;
  localparam logic [1:0] FCA_SCL_X16 = 2'h2;
  // Interrupt vector offsets.
  localparam logic [7:0] FCA_VEC_IN = 8'h68;
  localparam logic [7:0] FCA_VEC_OUT = 8'h6a;
  typedef enum logic [1:0] {
    FCA_IDLE = 2'b01,
    FCA_RUN = 2'b10
  } fca_state_t;
endpackage

// ### tb/fca_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Processor side of the register bus.
// ****************************************************************
module fca_host_model (
  // Bus clock.
  input wire logic i_clk,
  // APB master outputs.
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  // APB slave answer.
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr
);
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // The bench writes scale setup only while stopped, and one DCC write during run.
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    // Only the bench watchdog ends a wait that never sees ready.
    do
    begin
      @(posedge i_clk);
    end
    while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // Released lines show garbage so stale values are never trusted.
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
endmodule // fca_host_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
  import fca_pkg::*;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d, q;
  logic [2:0] ev = 3'h0;
  logic [1:0] fl = 2'h0;
  logic [23:0] mac = 24'h0, r;
  logic [23:0] scaled;
  logic run_on, irq_in, irq_out, dma11, dma12, e;
  logic [7:0] vec;
  logic [15:0] sa, ca, ch;
  int err_count = 0;
  int num_checks = 0;
  integer seed = 81;
  always #25 i_clk = ~i_clk;
  fca_host_model host (.i_clk(i_clk), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
    .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));
  fca_addr_config DUT (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sample_step(ev[0]), .i_coef_step(ev[1]),
    .i_session_start(ev[2]), .i_input_empty(fl[0]),
    .i_output_full(fl[1]), .i_mac_result(mac), .o_sample_addr(sa),
    .o_coef_addr(ca), .o_scaled_result(scaled), .o_run_on(run_on),
    .o_irq_in_req(irq_in), .o_irq_out_req(irq_out), .o_irq_vector(vec),
    .o_dma_req11(dma11), .o_dma_req12(dma12));
  function automatic logic [23:0] scl(input logic [1:0] c,
    input logic [23:0] v);
    case (c)
      2'h1: return v << 3;
      2'h2: return v << 4;
      default: return v;
    endcase
  endfunction
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x)
    begin
      $display("BAD %0t got %h exp %h", $time, g, x);
      err_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, q, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge i_clk);
    ev <= m;
    @(posedge i_clk);
    ev <= 3'h0;
  endtask
  task automatic flags(input logic [1:0] f, input logic [4:0] x);
    @(posedge i_clk);
    fl <= f;
    repeat (3) @(posedge i_clk);
    #1;
    chk({27'h0, run_on, dma12, dma11, irq_out, irq_in}, {27'h0, x});
  endtask
  initial
  begin
    #1000000;
    err_count++;
    give_verdict;
  end
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    rdc(FCA_ADDR_DCC, 32'h0);
    d = $random(seed);
    wr(FCA_ADDR_DCC, d);
    rdc(FCA_ADDR_DCC, d & 32'h00000f3f);
    wr(FCA_ADDR_LEN, 32'h4);
    wr(FCA_ADDR_SPTR, 32'h13);
    wr(FCA_ADDR_CPTR, 32'h20);
    for (int c = 0; c < 4; c++)
    begin
      wr(FCA_ADDR_ARITH, c);
      wr(FCA_ADDR_CTRL, 32'h1);
      repeat (3)
      begin
        r = $random(seed);
        @(posedge i_clk);
        mac <= r;
        @(posedge i_clk);
        #1;
        chk({8'h0, scaled}, {8'h0, scl(c[1:0], r)});
      end
      wr(FCA_ADDR_CTRL, 32'h0);
    end
    wr(FCA_ADDR_CTRL, 32'h1);
    pulse(3'h1);
    rdc(FCA_ADDR_SPTR, 32'h14);
    pulse(3'h1);
    rdc(FCA_ADDR_SPTR, 32'h10);
    pulse(3'h4);
    repeat (3) pulse(3'h2);
    rdc(FCA_ADDR_CPTR, 32'h20);
    rdc(FCA_ADDR_SCALE, 32'h23);
    ch = (d[5:0] != 6'h00) ? 16'h0008 : 16'h0000;
    #1;
    chk({sa, ca}, {16'h0010 + ch, 16'h0023 + ch});
    repeat (2) pulse(3'h2);
    rdc(FCA_ADDR_SCALE, 32'h24);
    wr(FCA_ADDR_DCC, 32'h0abc);
    rdc(FCA_ADDR_DCC, d & 32'h00000f3f);
    wr(FCA_ADDR_CTRL, 32'h7);
    flags(2'h1, 5'h15);
    chk({24'h0, vec}, {24'h0, FCA_VEC_IN});
    flags(2'h2, 5'h1a);
    chk({24'h0, vec}, {24'h0, FCA_VEC_OUT});
    flags(2'h3, 5'h1f);
    chk({24'h0, vec}, {24'h0, FCA_VEC_IN});
    wr(FCA_ADDR_CTRL, 32'h1);
    flags(2'h3, 5'h1c);
    wr(FCA_ADDR_CTRL, 32'h6);
    flags(2'h3, 5'h00);
    rdc(FCA_ADDR_SPTR, 32'h10);
    rdc(FCA_ADDR_LEN, 32'h4);
    rdc(FCA_ADDR_DCC, d & 32'h00000f3f);
    host.xfer(1'b0, 8'h20, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    give_verdict;
  end
endmodule // tb
